// ---- core/tcs_regs.sv ----
// Purpose: Tuner control/status register bank behind the two-wire port
// Assumes: SCL and SDA arrive from the host pins; status inputs on clk_sys_i
// Notes:   Link logic runs on SCL; writes cross by toggle, reads by freeze
// Operation
// - Control bit 7 picks mode, adds gain
// - Control bits 6..5 set baseband bias level
// - Control bit 4 selects high-side injection
// - Attack code maps -62 dBm plus 2 dB/step
// - Control bit 0 enables level detector
// - Divide code zero stops reference output
// - Power-down stops all but the port, keeps registers
// - Standby keeps oscillator and reference output
// - Divider bit 0 disables quadrature output
// - High register supplies divider bits 12..5
// - Low register bits 7..3 give bits 4..0
// - Status echoes pump current, bits 7..5 zero
// - Power-cycle flag set after reset
// - Stop during read clears power-cycle flag
// - Status bit 1 shows autoselect success
// - Status bit 0 low while autoselect runs
// - Reads return status first, then second
// - Writes fill successive registers until stop
module tcs_regs import tcs_pkg::*; (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              ce_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n_o,
  input  wire logic [1:0]        pump_current_i,
  input  wire logic              vco_autoselect_i,
  input  wire logic              vas_busy_i,
  input  wire logic              vas_pass_i,
  input  wire logic [7:0]        status_second_i,
  output logic                   qpsk_qam_select_o,
  output logic [1:0]             baseband_bias_sel_o,
  output logic                   lo_injection_side_o,
  output logic [2:0]             attack_point_sel_o,
  output logic signed [7:0]      attack_point_dbm_o,
  output logic                   level_detector_enable_o,
  output logic [4:0]             ref_clock_divide_sel_o,
  output logic                   buffered_ref_output_o,
  output logic                   power_down_ctl_o,
  output logic                   standby_ctl_o,
  output logic                   quad_out_disable_o,
  output logic                   signal_path_en_o,
  output logic                   xtal_osc_en_o,
  output logic                   q_channel_en_o,
  output logic [7:0]             ref_divider_o,
  output logic [12:0]            int_divider_o,
  output logic                   power_cycle_flag_o,
  output logic [7:0]             status_first_o
);
  // Attack point code to level in dBm
  function automatic logic signed [7:0] tcs_atk_dbm(input logic [2:0] code);
    logic signed [7:0] base;
    base = 8'(TCS_ATK_BASE_DBM);
    return base + 8'(TCS_ATK_STEP_DB) * $signed({5'h00, code});
  endfunction

  // Register storage
  logic [7:0] ctrl_r;       // signal_path_control
  logic [7:0] xtal_r;       // ref_output_divide_power
  logic [7:0] rdiv_r;       // reference_divider
  logic [7:0] nhi_r;        // integer_divider_high
  logic [4:0] nlo_r;        // integer_divider_low, used bits only
  logic       autoselect_success_r;       // autoselect_success
  logic       autoselect_idle_r;       // autoselect_idle
  logic [7:0] second_r;     // Second status byte snapshot
  logic       frame_rd_r;   // Read frame in progress
  logic [4:0] ref_cnt_r;    // Reference divider count

  // Link side wires
  logic [7:0] wr_addr_w;    // Pointer of last written byte
  logic [7:0] wr_data_w;    // Last written byte
  logic       wr_tgl_w;     // Toggles per written byte
  logic       rd_mode_w;    // Link in read frame
  logic [3:0] sync_w;       // Synchronised scl, sda, toggle, read
  logic       sda_d_r;      // Previous synchronised SDA
  logic       wr_d_r;       // Previous synchronised toggle
  logic       rd_d_r;       // Previous synchronised read level
  logic       scl_d_r;      // Previous synchronised SCL
  logic       sda_lo_r;     // SDA seen low since the last stop

  logic       scl_s;
  logic       sda_s;
  logic       wr_ev_w;
  logic       stop_w;
  logic       rd_rise_w;
  logic       xd_on_w;
  assign scl_s     = sync_w[0];
  assign sda_s     = sync_w[1];
  assign wr_ev_w   = sync_w[2] ^ wr_d_r;
  assign rd_rise_w = sync_w[3] & ~rd_d_r;
  // Stop needs SCL high on two samples; a data bit's high phase is shorter
  assign stop_w    = scl_s & scl_d_r & sda_s & sda_lo_r;
  assign xd_on_w   = ref_clock_divide_sel_o != 5'h00;

  // Serial-clock side of the port
  tcs_i2c_link u_link (
    .scl_i       (scl_i),
    .sda_i       (sda_i),
    .link_rst_i  (sys_rst_i),
    .rd_first_i  (status_first_o),
    .rd_second_i (second_r),
    .sda_o       (sda_o),
    .sda_oe_n_o  (sda_oe_n_o),
    .wr_addr_o   (wr_addr_w),
    .wr_data_o   (wr_data_w),
    .wr_tgl_o    (wr_tgl_w),
    .rd_mode_o   (rd_mode_w)
  );

  // Pins and link events into the system clock
  tcs_sync #(.WIDTH(4)) u_sync (
    .clk_i   (clk_sys_i),
    .rst_i   (sys_rst_i),
    .ce_i    (ce_i),
    .async_i ({rd_mode_w, wr_tgl_w, sda_i, scl_i}),
    .sync_o  (sync_w)
  );

  // Edge history of synchronised signals
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sda_d_r  <= 1'b1;
      wr_d_r   <= 1'b0;
      rd_d_r   <= 1'b0;
      scl_d_r  <= 1'b0;
      sda_lo_r <= 1'b0;
    end else if (ce_i) begin
      sda_d_r  <= sda_s;
      scl_d_r  <= scl_s;
      // Armed by any low SDA, spent by the stop it enables
      sda_lo_r <= ~sda_s | (sda_lo_r & ~stop_w);
      wr_d_r  <= sync_w[2];
      rd_d_r  <= sync_w[3];
    end
  end

  // Register writes from the link
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_r <= TCS_RST_CTRL;
      xtal_r <= TCS_RST_XTAL;
      rdiv_r <= TCS_RST_RDIV;
      nhi_r  <= TCS_RST_NHI;
      nlo_r  <= TCS_RST_NLO;
    end else if (ce_i && wr_ev_w) begin
      case (wr_addr_w)
        TCS_OFS_CTRL: ctrl_r <= wr_data_w;
        TCS_OFS_XTAL: xtal_r <= wr_data_w;
        TCS_OFS_RDIV: rdiv_r <= wr_data_w;
        TCS_OFS_NHI:  nhi_r  <= wr_data_w;
        TCS_OFS_NLO:  nlo_r  <= wr_data_w[7:TCS_NLO_LO];
        default: begin
          // Pointers outside the bank are ignored
        end
      endcase
    end
  end

  // Field outputs straight from the registers
  assign qpsk_qam_select_o      = ctrl_r[TCS_CTRL_MOD];
  assign baseband_bias_sel_o    = ctrl_r[TCS_CTRL_BBL_LO +: 2];
  assign lo_injection_side_o    = ctrl_r[TCS_CTRL_LO_INJECTION_SIDE];
  assign attack_point_sel_o     = ctrl_r[TCS_CTRL_PD_LO +: 3];
  assign ref_clock_divide_sel_o = xtal_r[TCS_XTAL_XD_LO +: 5];
  assign power_down_ctl_o       = xtal_r[TCS_XTAL_POWER_DOWN_CTL];
  assign standby_ctl_o          = xtal_r[TCS_XTAL_STANDBY_CTL];
  assign quad_out_disable_o     = xtal_r[TCS_XTAL_QUAD_OUT_DISABLE];
  assign ref_divider_o          = rdiv_r;
  assign int_divider_o          = {nhi_r, nlo_r};

  // Attack level in dBm, registered
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      attack_point_dbm_o <= 8'h00;
    end else if (ce_i) begin
      attack_point_dbm_o <= tcs_atk_dbm(attack_point_sel_o);
    end
  end

  // Power states gate the functional enables
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      signal_path_en_o        <= 1'b0;
      xtal_osc_en_o           <= 1'b0;
      q_channel_en_o          <= 1'b0;
      level_detector_enable_o <= 1'b0;
    end else if (ce_i) begin
      // Power-down keeps only the port; registers untouched
      xtal_osc_en_o    <= ~power_down_ctl_o;
      // Standby also drops the signal path, quadrature channel and level detector
      signal_path_en_o <= ~power_down_ctl_o & ~standby_ctl_o;
      q_channel_en_o   <= ~power_down_ctl_o & ~standby_ctl_o
                          & ~quad_out_disable_o;
      level_detector_enable_o <= ~power_down_ctl_o & ~standby_ctl_o
                                 & ctrl_r[TCS_CTRL_EPD];
    end
  end

  // Reference output divider, alive in standby
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ref_cnt_r             <= 5'h00;
      buffered_ref_output_o <= 1'b0;
    end else if (ce_i) begin
      if (!xd_on_w || power_down_ctl_o) begin
        ref_cnt_r             <= 5'h00;  // Buffer off
        buffered_ref_output_o <= 1'b0;
      end else if (ref_cnt_r + 5'h01 >= ref_clock_divide_sel_o) begin
        ref_cnt_r             <= 5'h00;  // One tick per divide count
        buffered_ref_output_o <= 1'b1;
      end else begin
        ref_cnt_r             <= ref_cnt_r + 5'h01;
        buffered_ref_output_o <= 1'b0;
      end
    end
  end

  // Read frame tracking; the stop ends it here
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      frame_rd_r <= 1'b0;
    end else if (ce_i) begin
      if (rd_rise_w) begin
        frame_rd_r <= 1'b1;
      end else if (stop_w) begin
        frame_rd_r <= 1'b0;
      end
    end
  end

  // Power-cycle flag
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      power_cycle_flag_o <= 1'b1;  // Defaults loaded
    end else if (ce_i && stop_w && frame_rd_r) begin
      power_cycle_flag_o <= 1'b0;
    end
  end

  // Autoselect status bits
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      autoselect_success_r <= 1'b0;
      autoselect_idle_r <= 1'b1;
    end else if (ce_i) begin
      autoselect_success_r <= vco_autoselect_i & vas_pass_i & ~vas_busy_i;
      autoselect_idle_r <= ~vas_busy_i;
    end
  end

  // Status snapshot, frozen while a read frame runs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      status_first_o <= 8'h00;
      second_r       <= 8'h00;
    end else if (ce_i && !frame_rd_r && !rd_rise_w) begin
      status_first_o <= {3'h0, pump_current_i, power_cycle_flag_o,
                         autoselect_success_r, autoselect_idle_r};
      second_r       <= status_second_i;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  logic wr_ctrl_w;
  logic wr_xtal_w;
  assign wr_ctrl_w = ce_i && wr_ev_w && (wr_addr_w == TCS_OFS_CTRL);
  assign wr_xtal_w = ce_i && wr_ev_w && (wr_addr_w == TCS_OFS_XTAL);

  chk_gain_mode: assert property (wr_ctrl_w |=> qpsk_qam_select_o == wr_data_w[7])
    else $error("mode bit not taken from control write");
  chk_bias_field: assert property (wr_ctrl_w |=> baseband_bias_sel_o == wr_data_w[6:5])
    else $error("bias field not taken from control write");
  chk_lo_side: assert property (wr_ctrl_w |=> lo_injection_side_o == wr_data_w[4])
    else $error("injection side not taken from control write");
  chk_attack_dbm: assert property (ce_i |=>
      attack_point_dbm_o == 8'(-62) + 8'(2) * $signed({5'h00, $past(attack_point_sel_o)}))
    else $error("attack level does not follow code");
  chk_detector_gate: assert property (ce_i && !ctrl_r[0] |=> !level_detector_enable_o)
    else $error("level detector on while disabled");
  chk_ref_off: assert property (!xd_on_w [*2] |-> !buffered_ref_output_o)
    else $error("reference output ticks with divide code zero");
  chk_power_down: assert property (ce_i && power_down_ctl_o |=>
      !signal_path_en_o && !xtal_osc_en_o && !q_channel_en_o)
    else $error("functions alive in power-down");
  chk_standby_keep: assert property (ce_i && standby_ctl_o && !power_down_ctl_o |=>
      !signal_path_en_o && xtal_osc_en_o)
    else $error("standby enables wrong");
  chk_quad_off: assert property (wr_xtal_w && wr_data_w[0] ##1 ce_i |=> !q_channel_en_o)
    else $error("quadrature output on while disabled");
  chk_ndiv_form: assert property (ce_i && wr_ev_w && wr_addr_w == TCS_OFS_NLO |=>
      int_divider_o[4:0] == wr_data_w[7:3])
    else $error("divider low bits not from bits 7..3");
  chk_status_unused: assert property (status_first_o[7:5] == 3'h0)
    else $error("unused status bits not zero");
  chk_pwr_sticky: assert property (!power_cycle_flag_o |=> !power_cycle_flag_o)
    else $error("power-cycle flag set without reset");
  chk_pwr_clear: assert property (ce_i && stop_w && frame_rd_r |=> !power_cycle_flag_o)
    else $error("stop in read did not clear flag");
  chk_vas_busy: assert property (ce_i && vas_busy_i |=> !autoselect_idle_r && !autoselect_success_r)
    else $error("autoselect status wrong while running");

  cov_ctrl_write: cover property (wr_ctrl_w);
  cov_read_stop: cover property (frame_rd_r ##1 !frame_rd_r);
  cov_ref_tick: cover property (buffered_ref_output_o ##1 buffered_ref_output_o);
  cov_standby: cover property (standby_ctl_o && xtal_osc_en_o);
endmodule

// ---- core/tcs_pkg.sv ----
// Purpose: Shared constants and types of the tuner control/status bank
// Assumes: 8-bit registers reached over the two-wire serial port
// Notes:   Register pointer values are the byte sent after the write address
package tcs_pkg;
  // Seven-bit serial slave address
  localparam logic [6:0] TCS_SLAVE_ADDR = 7'h60;
  // Register pointer values
  localparam logic [7:0] TCS_OFS_CTRL   = 8'h00;
  localparam logic [7:0] TCS_OFS_XTAL   = 8'h01;
  localparam logic [7:0] TCS_OFS_RDIV   = 8'h02;
  localparam logic [7:0] TCS_OFS_NHI    = 8'h03;
  localparam logic [7:0] TCS_OFS_NLO    = 8'h04;
  // Reset (recommended default) values
  localparam logic [7:0] TCS_RST_CTRL   = 8'h56;
  localparam logic [7:0] TCS_RST_XTAL   = 8'h08;
  localparam logic [7:0] TCS_RST_RDIV   = 8'h38;
  localparam logic [7:0] TCS_RST_NHI    = 8'h53;
  localparam logic [4:0] TCS_RST_NLO    = 5'h1f;
  // Field positions, control register
  localparam int TCS_CTRL_MOD    = 7;
  localparam int TCS_CTRL_BBL_LO = 5;
  localparam int TCS_CTRL_LO_INJECTION_SIDE   = 4;
  localparam int TCS_CTRL_PD_LO  = 1;
  localparam int TCS_CTRL_EPD    = 0;
  // Field positions, divide/power register
  localparam int TCS_XTAL_XD_LO  = 3;
  localparam int TCS_XTAL_POWER_DOWN_CTL   = 2;
  localparam int TCS_XTAL_STANDBY_CTL   = 1;
  localparam int TCS_XTAL_QUAD_OUT_DISABLE   = 0;
  // Integer divider low bits sit at 7..3 of the low register
  localparam int TCS_NLO_LO      = 3;
  // Attack point mapping in dBm
  localparam int TCS_ATK_BASE_DBM = -62;
  localparam int TCS_ATK_STEP_DB  = 2;
  // Host-side programming limits
  localparam int TCS_RDIV_MIN = 22;
  localparam int TCS_RDIV_MAX = 182;
  localparam int TCS_NDIV_MIN = 829;
  localparam int TCS_NDIV_MAX = 5374;
  // Serial link phases, Gray along address, pointer, write
  typedef enum logic [2:0] {
    TCS_PH_IDLE  = 3'b000,
    TCS_PH_ADDR  = 3'b001,
    TCS_PH_REG   = 3'b011,
    TCS_PH_WDATA = 3'b010,
    TCS_PH_RDATA = 3'b110
  } tcs_phase_e;
endpackage

// ---- core/tcs_sync.sv ----
// Purpose: Two-flop level synchroniser, one lane per bit
// Assumes: Inputs are quasi-static levels or toggles
// Notes:   First stage feeds only the second stage
module tcs_sync import tcs_pkg::*; #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;  // First stage

  // Two stages, frozen with the clock enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// ---- core/tcs_i2c_link.sv ----
// Purpose: Serial-clock side of the two-wire slave port
// Assumes: Pin protocol timing keeps SDA stable while SCL is high
// Notes:   Reset acts asynchronously since SCL stands still when idle
module tcs_i2c_link import tcs_pkg::*; (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       link_rst_i,
  input  wire logic [7:0] rd_first_i,
  input  wire logic [7:0] rd_second_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  output logic [7:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  output logic            wr_tgl_o,
  output logic            rd_mode_o
);
  logic       start_tgl_r;   // Flips on each start marker
  logic       start_seen_r;  // Last start marker consumed
  logic       sda_pos_r;     // SDA taken at SCL rise
  logic [3:0] bit_cnt_r;     // Bit slot within byte, 8 = ack
  logic [7:0] shift_r;       // Incoming bits
  logic [7:0] ptr_r;         // Register pointer
  logic [7:0] tx_r;          // Outgoing bits
  logic       rd_idx_r;      // Which status byte goes next
  logic       drive_low_r;   // Pulling SDA low
  tcs_phase_e phase_r;       // Transaction phase

  logic       start_w;
  logic [7:0] byte_w;
  logic [7:0] rd_byte_w;
  logic       ack_w;
  assign start_w   = start_tgl_r ^ start_seen_r;
  assign byte_w    = {shift_r[6:0], sda_pos_r};
  assign rd_byte_w = rd_idx_r ? rd_second_i : rd_first_i;
  assign ack_w     = ((phase_r == TCS_PH_ADDR) && (byte_w[7:1] == TCS_SLAVE_ADDR))
                   || (phase_r == TCS_PH_REG) || (phase_r == TCS_PH_WDATA);
  assign sda_o      = 1'b0;          // Open drain: only ever pulls low
  assign sda_oe_n_o = ~drive_low_r;

  // Start marker: SDA falls while SCL is high
  always_ff @(negedge sda_i or posedge link_rst_i) begin
    if (link_rst_i) begin
      start_tgl_r <= 1'b0;
    end else if (scl_i) begin
      start_tgl_r <= ~start_tgl_r;
    end
  end

  // Data bit sample on SCL rise
  always_ff @(posedge scl_i or posedge link_rst_i) begin
    if (link_rst_i) begin
      sda_pos_r <= 1'b1;
    end else begin
      sda_pos_r <= sda_i;
    end
  end

  // Byte framing and phase on SCL fall
  always_ff @(negedge scl_i or posedge link_rst_i) begin
    if (link_rst_i) begin
      start_seen_r <= 1'b0;
      bit_cnt_r    <= 4'h0;
      shift_r      <= 8'h00;
      ptr_r        <= 8'h00;
      wr_addr_o    <= 8'h00;
      wr_data_o    <= 8'h00;
      wr_tgl_o     <= 1'b0;
      rd_mode_o    <= 1'b0;
      phase_r      <= TCS_PH_IDLE;
    end else begin
      start_seen_r <= start_tgl_r;
      if (start_w) begin
        // New frame: wait for the slave address
        bit_cnt_r <= 4'h0;
        rd_mode_o <= 1'b0;
        phase_r   <= TCS_PH_ADDR;
      end else if (bit_cnt_r == 4'h8) begin
        bit_cnt_r <= 4'h0;
        if ((phase_r == TCS_PH_RDATA) && sda_pos_r) begin
          phase_r <= TCS_PH_IDLE;  // Master refused further bytes
        end
      end else begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
        shift_r   <= byte_w;
        if (bit_cnt_r == 4'h7) begin
          case (phase_r)
            TCS_PH_ADDR: begin
              if (byte_w[7:1] == TCS_SLAVE_ADDR) begin
                phase_r   <= byte_w[0] ? TCS_PH_RDATA : TCS_PH_REG;
                rd_mode_o <= byte_w[0];
              end else begin
                phase_r <= TCS_PH_IDLE;  // Not for us
              end
            end
            TCS_PH_REG: begin
              ptr_r   <= byte_w;
              phase_r <= TCS_PH_WDATA;
            end
            TCS_PH_WDATA: begin
              // Hand byte over, step to next register
              wr_addr_o <= ptr_r;
              wr_data_o <= byte_w;
              wr_tgl_o  <= ~wr_tgl_o;
              ptr_r     <= ptr_r + 8'h01;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // SDA drive: acks, then status bytes MSB first
  always_ff @(negedge scl_i or posedge link_rst_i) begin
    if (link_rst_i) begin
      drive_low_r <= 1'b0;
      tx_r        <= 8'h00;
      rd_idx_r    <= 1'b0;
    end else if (start_w) begin
      drive_low_r <= 1'b0;
      rd_idx_r    <= 1'b0;
    end else if (bit_cnt_r == 4'h7) begin
      drive_low_r <= ack_w;
    end else if (bit_cnt_r == 4'h8) begin
      if ((phase_r == TCS_PH_RDATA) && !sda_pos_r) begin
        // First status byte, then second
        drive_low_r <= ~rd_byte_w[7];
        tx_r        <= {rd_byte_w[6:0], 1'b0};
        rd_idx_r    <= ~rd_idx_r;
      end else begin
        drive_low_r <= 1'b0;
      end
    end else if (phase_r == TCS_PH_RDATA) begin
      drive_low_r <= ~tx_r[7];
      tx_r        <= {tx_r[6:0], 1'b0};
    end else begin
      drive_low_r <= 1'b0;
    end
  end
endmodule

// ---- verif/tcs_host_model.sv ----
// Purpose: Host master model driving the two-wire port
// Assumes: Pull-up on SDA; the wired level comes back on sda_i
// Notes:   Bit period 48 ns; SCL stands high between frames
module tcs_host_model (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idle at time zero
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Frame opens: SDA falls while SCL high
  task automatic start;
    sda_o = 1'b1;
    scl_o = 1'b1;
    #24 sda_o = 1'b0;
    #24 scl_o = 1'b0;
  endtask
  // Frame closes: SDA rises while SCL high
  task automatic stop;
    #6 sda_o = 1'b0;
    #18 scl_o = 1'b1;
    #24 sda_o = 1'b1;
    #24;
  endtask
  // Data moves only in the low phase, sampled mid high phase
  task automatic bit_io(input logic v, output logic r);
    #6 sda_o = v;
    #18 scl_o = 1'b1;
    #12 r = sda_i;
    #12 scl_o = 1'b0;
  endtask
  // Byte MSB first, then the acknowledge clock
  task automatic byte_io(input logic [7:0] w, input logic ak_i, output logic [7:0] r,
                         output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(ak_i, ak);
  endtask
endmodule

// ---- verif/tuner_control_status_regs_test.sv ----
// Purpose: Self-checking bench of the tuner control/status bank
// Assumes: Host model on the serial pins, status inputs on clk_sys_i
// Notes:   Control registers are write-only, so fields are judged at the outputs
module tuner_control_status_regs_test import tcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, scl_i, sda_m, sda_o, sda_oe_n_o;
  logic [1:0] pump_current_i = 2'b00, baseband_bias_sel_o;
  logic vco_autoselect_i = 1'b0, vas_busy_i = 1'b0, vas_pass_i = 1'b0;
  logic [7:0] status_second_i = 8'h5a, ref_divider_o, status_first_o;
  logic qpsk_qam_select_o, lo_injection_side_o, level_detector_enable_o, buffered_ref_output_o;
  logic power_down_ctl_o, standby_ctl_o, quad_out_disable_o, signal_path_en_o, xtal_osc_en_o;
  logic q_channel_en_o, power_cycle_flag_o;
  logic [2:0] attack_point_sel_o;
  logic signed [7:0] attack_point_dbm_o;
  logic [4:0] ref_clock_divide_sel_o;
  logic [12:0] int_divider_o;
  int fails = 0, samples_checked = 0;
  // Wired-AND bus level with pull-up
  wire sda_i = sda_m & (sda_oe_n_o | sda_o);
  // Control fields and power/enable state gathered for compact checks
  wire [7:0] ctl = {qpsk_qam_select_o, baseband_bias_sel_o, lo_injection_side_o,
                    attack_point_sel_o, level_detector_enable_o};
  wire [6:0] power_cycle_flag = {power_down_ctl_o, standby_ctl_o, quad_out_disable_o, xtal_osc_en_o,
                    signal_path_en_o, q_channel_en_o, level_detector_enable_o};
  tcs_regs dut_u (.*);
  tcs_host_model h_u (.scl_o(scl_i), .sda_o(sda_m), .sda_i(sda_i));
  always #20 clk_sys_i = ~clk_sys_i;
  task automatic close_out;
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Count reference output pulses over n cycles
  task automatic pulses(input int n, input int exp);
    int k;
    k = 0;
    repeat (n) begin
      @(negedge clk_sys_i);
      if (buffered_ref_output_o === 1'b1) k++;
    end
    chk(16'(k), 16'(exp));
  endtask
  // Write frame, n bytes from the top of d, each acked when the address matches
  task automatic wr(input logic [6:0] adr, input logic [7:0] ptr, input logic [39:0] d,
                    input int n);
    logic [7:0] r;
    logic a;
    h_u.start;
    h_u.byte_io({adr, 1'b0}, 1'b1, r, a);
    chk(a, adr != TCS_SLAVE_ADDR);
    h_u.byte_io(ptr, 1'b1, r, a);
    for (int i = 0; i < n; i++) h_u.byte_io(d[39-8*i -: 8], 1'b1, r, a);
    h_u.stop;
    repeat (6) @(negedge clk_sys_i);
  endtask
  task automatic t_defaults;
    chk(ctl, 8'h56);
    chk({8'h00, attack_point_dbm_o}, 16'h00c8);
    chk(int_divider_o, 13'd2687);
    chk(power_cycle_flag_o, 1'b1);
    chk(ref_clock_divide_sel_o, 5'h01);
  endtask
  task automatic t_burst;
    wr(TCS_SLAVE_ADDR, TCS_OFS_CTRL, {8'h8f, 8'h0d, 8'd22, 8'h1a, 8'h3f}, 5);
    chk(ctl, 8'h8e);
    chk({8'h00, attack_point_dbm_o}, 16'h00d0);
    chk(power_cycle_flag, 7'b1010000);
    pulses(8, 0);
    chk(ref_divider_o, 8'd22);
    chk(int_divider_o, {8'h1a, 5'h07});
  endtask
  task automatic t_power;
    wr(TCS_SLAVE_ADDR, TCS_OFS_XTAL, {8'h0a, 32'h0}, 1);
    chk(power_cycle_flag, 7'b0101000);
    pulses(8, 8);
    wr(TCS_SLAVE_ADDR, TCS_OFS_XTAL, {8'h18, 32'h0}, 1);
    chk(power_cycle_flag, 7'b0001111);
    pulses(30, 10);
    wr(TCS_SLAVE_ADDR, TCS_OFS_XTAL, {8'h01, 32'h0}, 1);
    chk(power_cycle_flag, 7'b0011101);
    pulses(30, 0);
  endtask
  // Wrong address and unmapped pointer leave the bank alone
  task automatic t_fields;
    wr(TCS_SLAVE_ADDR, TCS_OFS_CTRL, {8'h70, 32'h0}, 1);
    wr(7'h61, TCS_OFS_CTRL, {8'h8f, 32'h0}, 1);
    wr(TCS_SLAVE_ADDR, 8'h05, {8'hff, 32'h0}, 1);
    chk(ctl, 8'h70);
    chk({8'h00, attack_point_dbm_o}, 16'h00c2);
    chk(ref_divider_o, 8'd22);
  endtask
  task automatic t_status;
    logic [7:0] r;
    logic a;
    // Clock enable low freezes the status snapshot
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    pump_current_i <= 2'b11;
    repeat (4) @(negedge clk_sys_i);
    chk(status_first_o, 8'h05);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    @(posedge clk_sys_i);
    pump_current_i <= 2'b01;
    vco_autoselect_i <= 1'b1;
    vas_busy_i <= 1'b1;
    vas_pass_i <= 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk(status_first_o, 8'h0c);
    @(posedge clk_sys_i);
    pump_current_i <= 2'b10;
    vas_busy_i <= 1'b0;
    repeat (4) @(negedge clk_sys_i);
    chk(status_first_o, 8'h17);
    h_u.start;
    h_u.byte_io({TCS_SLAVE_ADDR, 1'b1}, 1'b1, r, a);
    h_u.byte_io(8'hff, 1'b0, r, a);
    chk(r, 8'h17);
    h_u.byte_io(8'hff, 1'b1, r, a);
    chk(r, 8'h5a);
    h_u.stop;
    repeat (6) @(negedge clk_sys_i);
    chk(power_cycle_flag_o, 1'b0);
    chk(status_first_o, 8'h13);
  endtask
  // Watchdog cuts a hung run short
  initial begin
    #100000;
    fails++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (5) @(negedge clk_sys_i);
    t_defaults;
    t_burst;
    t_power;
    t_fields;
    t_status;
    close_out;
  end
endmodule
